// ==== logic/arsr_device.sv ====
/*
  Converter end of the readout link: conversion sequencing on the master clock
  and the reader-clocked serial result port.
  Assumes filter words and range flags come from the converter core on the master
  clock; convert, channel, polarity, select and shift clock are asynchronous pins.
*/
`timescale 1ns/1ps
module arsr_device (
  // Link to the reader, clocked by the master clock.
  arsr_link_if.dev                          link,
  // Reset, synchronous to the master clock.
  input  wire logic                         rst_n,
  // Converter control pins.
  input  wire logic                         convertCmd,
  input  wire logic                         channelPick,
  input  wire logic                         polaritySelect,
  // Filter results and range flags per channel.
  input  wire logic [arsr_pkg::RESULT_W-1:0] filterWordA,
  input  wire logic                         overRangeA,
  input  wire logic                         underRangeA,
  input  wire logic [arsr_pkg::RESULT_W-1:0] filterWordB,
  input  wire logic                         overRangeB,
  input  wire logic                         underRangeB,
  // Status.
  output logic                              converting
);

  localparam logic [arsr_pkg::CONV_CNT_W-1:0] STANDBY_LOAD =
    arsr_pkg::CONV_CNT_W'(arsr_pkg::CONV_STANDBY_CYC - 1);
  localparam logic [arsr_pkg::CONV_CNT_W-1:0] CONT_LOAD =
    arsr_pkg::CONV_CNT_W'(arsr_pkg::CONV_CONTINUOUS_CYC - 1);

  // Pin synchronisers: bit 0 feeds only bit 1.
  logic [1:0]                         convSync_q;
  logic [1:0]                         chanSync_q;
  logic [1:0]                         polSync_q;
  logic [1:0]                         selSync_q;
  logic [1:0]                         sclkSync_q;
  logic                               convPrev_q;
  logic                               sclkPrev_q;

  // Conversion sequencer.
  arsr_pkg::arsr_conv_state_t         convState_q;
  arsr_pkg::arsr_conv_state_t         convState_d;
  logic [arsr_pkg::CONV_CNT_W-1:0]    convCnt_q;
  logic [arsr_pkg::CONV_CNT_W-1:0]    convCnt_d;
  logic                               chan_q;
  logic                               chan_d;
  logic                               converting_q;

  // Serial port.
  arsr_pkg::arsr_port_state_t         portState_q;
  arsr_pkg::arsr_port_state_t         portState_d;
  logic [arsr_pkg::RESULT_W-1:0]      word_q;
  logic [arsr_pkg::RESULT_W-1:0]      word_d;
  logic [arsr_pkg::RESULT_W-1:0]      shift_q;
  logic [arsr_pkg::RESULT_W-1:0]      shift_d;
  logic [4:0]                         bitIdx_q;
  logic [4:0]                         bitIdx_d;
  logic                               armed_q;
  logic                               armed_d;
  logic                               dataOut_q;
  logic                               dataOut_d;
  logic                               dataOe_q;
  logic                               dataOe_d;
  logic                               readyN_q;
  logic                               readyN_d;

  // Decoded events.
  logic                               convRise;
  logic                               convDone;
  logic                               convRestart;
  logic                               sclkRise;
  logic                               sclkFall;
  logic                               selActive;
  logic                               update;
  logic                               wordDone;
  logic [arsr_pkg::RESULT_W-1:0]      pickedWord;
  logic                               pickedOver;
  logic                               pickedUnder;
  logic [arsr_pkg::RESULT_W-1:0]      offsetWord;
  logic [arsr_pkg::RESULT_W-1:0]      resultCode;

  assign convRise    = convSync_q[1] & ~convPrev_q;
  assign sclkRise    = sclkSync_q[1] & ~sclkPrev_q;
  assign sclkFall    = ~sclkSync_q[1] & sclkPrev_q;
  assign selActive   = ~selSync_q[1];

  assign convDone    = (convState_q == arsr_pkg::DEV_CONVERT) && (convCnt_q == '0);
  // A rise mid-conversion aborts it; a held command chains the next one.
  assign convRestart = convRise | (convDone & convSync_q[1]);
  assign convState_d = convRestart ? arsr_pkg::DEV_CONVERT :
                       convDone    ? arsr_pkg::DEV_STANDBY : convState_q;
  assign convCnt_d   = convRise ? STANDBY_LOAD :
                       convDone ? CONT_LOAD :
                       (convState_q == arsr_pkg::DEV_CONVERT) ? convCnt_q - 1'b1 : convCnt_q;
  assign chan_d      = convRise ? chanSync_q[1] : chan_q;

  assign pickedWord  = chan_q ? filterWordB : filterWordA;
  assign pickedOver  = chan_q ? overRangeB : overRangeA;
  assign pickedUnder = chan_q ? underRangeB : underRangeA;
  assign offsetWord  = pickedWord + arsr_pkg::BIPOLAR_OFFSET;
  // Polarity is not latched: it is read as the result is loaded.
  assign resultCode  = pickedOver  ? arsr_pkg::CODE_ALL_ONES :
                       pickedUnder ? arsr_pkg::CODE_ALL_ZEROS :
                       polSync_q[1] ? offsetWord : pickedWord;

  // A result finishing during a read is dropped so the word being shifted stays intact.
  assign update   = convDone && (portState_q == arsr_pkg::PORT_IDLE);
  assign wordDone = (portState_q == arsr_pkg::PORT_SHIFT) && sclkFall && armed_q &&
                    (bitIdx_q == arsr_pkg::LAST_BIT);
  assign word_d   = update ? resultCode : word_q;
  assign readyN_d = update ? 1'b0 : wordDone ? 1'b1 : readyN_q;

  always_comb
  begin
    portState_d = portState_q;
    shift_d     = shift_q;
    bitIdx_d    = bitIdx_q;
    armed_d     = armed_q;
    dataOut_d   = dataOut_q;
    dataOe_d    = dataOe_q;
    unique case (portState_q)
      arsr_pkg::PORT_IDLE:
      begin
        // The select counts only once it is synchronised and a result waits.
        if (selActive && !readyN_q)
        begin
          portState_d = arsr_pkg::PORT_SHIFT;
          dataOe_d    = 1'b1;
          dataOut_d   = word_q[arsr_pkg::RESULT_W-1];
          shift_d     = {word_q[arsr_pkg::RESULT_W-2:0], 1'b0};
          bitIdx_d    = '0;
          armed_d     = 1'b0;
        end
      end
      arsr_pkg::PORT_SHIFT:
      begin
        if (sclkRise)
        begin
          armed_d = 1'b1;
        end
        if (sclkFall && armed_q)
        begin
          if (bitIdx_q == arsr_pkg::LAST_BIT)
          begin
            portState_d = arsr_pkg::PORT_IDLE;
            dataOe_d    = 1'b0;
          end
          else
          begin
            dataOut_d = shift_q[arsr_pkg::RESULT_W-1];
            shift_d   = {shift_q[arsr_pkg::RESULT_W-2:0], 1'b0};
            bitIdx_d  = bitIdx_q + 5'h01;
          end
        end
        else if (!selActive)
        begin
          portState_d = arsr_pkg::PORT_DRAIN;
        end
      end
      arsr_pkg::PORT_DRAIN:
      begin
        // Before any rising edge no bit is under way, so the line floats at once.
        if ((sclkFall && armed_q) || !armed_q)
        begin
          portState_d = arsr_pkg::PORT_IDLE;
          dataOe_d    = 1'b0;
        end
      end
      default:
      begin
        portState_d = arsr_pkg::PORT_IDLE;
        dataOe_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.masterClk)
  begin
    if (!rst_n)
    begin
      convSync_q <= 2'h0;
      chanSync_q <= 2'h0;
      polSync_q  <= 2'h0;
      selSync_q  <= 2'h3;
      sclkSync_q <= 2'h0;
      convPrev_q <= 1'b0;
      sclkPrev_q <= 1'b0;
    end
    else
    begin
      convSync_q <= {convSync_q[0], convertCmd};
      chanSync_q <= {chanSync_q[0], channelPick};
      polSync_q  <= {polSync_q[0], polaritySelect};
      selSync_q  <= {selSync_q[0], link.selectN};
      sclkSync_q <= {sclkSync_q[0], link.shiftClk};
      convPrev_q <= convSync_q[1];
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  always_ff @(posedge link.masterClk)
  begin
    if (!rst_n)
    begin
      convState_q  <= arsr_pkg::DEV_STANDBY;
      convCnt_q    <= '0;
      chan_q       <= 1'b0;
      converting_q <= 1'b0;
    end
    else
    begin
      convState_q  <= convState_d;
      convCnt_q    <= convCnt_d;
      chan_q       <= chan_d;
      converting_q <= (convState_d == arsr_pkg::DEV_CONVERT);
    end
  end

  always_ff @(posedge link.masterClk)
  begin
    if (!rst_n)
    begin
      portState_q <= arsr_pkg::PORT_IDLE;
      word_q      <= '0;
      shift_q     <= '0;
      bitIdx_q    <= '0;
      armed_q     <= 1'b0;
      dataOut_q   <= 1'b0;
      dataOe_q    <= 1'b0;
      readyN_q    <= 1'b1;
    end
    else
    begin
      portState_q <= portState_d;
      word_q      <= word_d;
      shift_q     <= shift_d;
      bitIdx_q    <= bitIdx_d;
      armed_q     <= armed_d;
      dataOut_q   <= dataOut_d;
      dataOe_q    <= dataOe_d;
      readyN_q    <= readyN_d;
    end
  end

  assign link.serialResultOut = dataOut_q;
  assign link.serialResultOe  = dataOe_q;
  assign link.resultReadyN    = readyN_q;
  assign converting           = converting_q;

endmodule // arsr_device

// ==== logic/arsr_pkg.sv ====
/*
  Shared constants and state types for the serial result readout link:
  result width, conversion lengths, offsets and host timing figures.
  Assumes a 250 MHz host clock and a master clock given by the surrounding logic.
*/
package arsr_pkg;

  // Result word.
  localparam int              RESULT_W       = 20;
  localparam logic [4:0]      LAST_BIT       = 5'h13;
  localparam logic [19:0]     BIPOLAR_OFFSET = 20'h80000;
  localparam logic [19:0]     CODE_ALL_ONES  = 20'hFFFFF;
  localparam logic [19:0]     CODE_ALL_ZEROS = 20'h00000;

  // Conversion lengths in master clock cycles.
  localparam int              CONV_CNT_W          = 11;
  localparam int              CONV_STANDBY_CYC    = 1624;
  localparam int              CONV_CONTINUOUS_CYC = 1622;

  // Host timing.
  localparam int              CLK_PERIOD_NS    = 4;
  localparam int              SEL_EXTRA_NS     = 200;
  localparam int              SEL_WAIT_MCLKS   = 2;
  localparam int              SHIFT_HALF_MCLKS = 4;
  localparam int              HOST_CNT_W       = 17;
  localparam logic [4:0]      HOST_BITS        = 5'h14;

  typedef enum logic {DEV_STANDBY, DEV_CONVERT} arsr_conv_state_t;

  typedef enum logic [1:0] {PORT_IDLE, PORT_SHIFT, PORT_DRAIN} arsr_port_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_WAIT_READY,
    HOST_SETUP,
    HOST_HIGH,
    HOST_LOW,
    HOST_RELEASE
  } arsr_host_state_t;

endpackage

// ==== logic/arsr_link_if.sv ====
/*
  The pins between the converter and its reader.
  Assumes the bench drives masterClk; the data wire reads low while nobody drives it.
*/
`timescale 1ns/1ps
interface arsr_link_if (
  input wire logic masterClk
);
  logic selectN;
  logic shiftClk;
  logic serialResultOut;
  logic serialResultOe;
  logic resultReadyN;
  logic serialLine;

  // Resolved level of the three-state data wire.
  assign serialLine = serialResultOe ? serialResultOut : 1'b0;

  modport dev (
    input  masterClk,
    input  selectN,
    input  shiftClk,
    output serialResultOut,
    output serialResultOe,
    output resultReadyN
  );

  modport host (
    input  serialLine,
    input  resultReadyN,
    output selectN,
    output shiftClk
  );
endinterface

// ==== logic/arsr_host.sv ====
/*
  Reader end of the readout link: selects the port, makes the shift clock by
  dividing core_clk, and collects a 20-bit word MSB first.
  Assumes the master clock period is given by parameter; all link inputs are asynchronous.
*/
`timescale 1ns/1ps
module arsr_host #(
  parameter int MCLK_PERIOD_NS = 33334
) (
  // Clock and reset.
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Link to the converter.
  arsr_link_if.host                          link,
  // User side.
  input  wire logic                          readReq,
  output logic [arsr_pkg::RESULT_W-1:0]      readData,
  output logic                               readValid,
  output logic                               busy
);

  // The select wait is a least time, so it rounds up.
  localparam int SETUP_NS   = arsr_pkg::SEL_WAIT_MCLKS * MCLK_PERIOD_NS + arsr_pkg::SEL_EXTRA_NS;
  localparam int SETUP_CYC  = (SETUP_NS + arsr_pkg::CLK_PERIOD_NS - 1) / arsr_pkg::CLK_PERIOD_NS;
  // Each shift phase lasts several master clocks so the converter can sample it.
  localparam int HALF_NS    = arsr_pkg::SHIFT_HALF_MCLKS * MCLK_PERIOD_NS;
  localparam int HALF_CYC   = (HALF_NS + arsr_pkg::CLK_PERIOD_NS - 1) / arsr_pkg::CLK_PERIOD_NS;
  localparam logic [arsr_pkg::HOST_CNT_W-1:0] SETUP_LOAD = arsr_pkg::HOST_CNT_W'(SETUP_CYC - 1);
  localparam logic [arsr_pkg::HOST_CNT_W-1:0] HALF_LOAD  = arsr_pkg::HOST_CNT_W'(HALF_CYC - 1);

  logic [1:0]                         readySync_q;
  logic [1:0]                         dataSync_q;
  arsr_pkg::arsr_host_state_t         state_q;
  arsr_pkg::arsr_host_state_t         state_d;
  logic [arsr_pkg::HOST_CNT_W-1:0]    cnt_q;
  logic [arsr_pkg::HOST_CNT_W-1:0]    cnt_d;
  logic [4:0]                         bits_q;
  logic [4:0]                         bits_d;
  logic [arsr_pkg::RESULT_W-1:0]      data_q;
  logic [arsr_pkg::RESULT_W-1:0]      data_d;
  logic                               selN_q;
  logic                               selN_d;
  logic                               sclk_q;
  logic                               sclk_d;
  logic                               valid_q;
  logic                               valid_d;
  logic                               busy_q;
  logic                               cntZero;
  logic [arsr_pkg::RESULT_W-1:0]      sampled;

  assign cntZero = (cnt_q == '0);
  assign sampled = {data_q[arsr_pkg::RESULT_W-2:0], dataSync_q[1]};

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cntZero ? cnt_q : cnt_q - 1'b1;
    bits_d  = bits_q;
    data_d  = data_q;
    selN_d  = selN_q;
    sclk_d  = sclk_q;
    valid_d = 1'b0;
    unique case (state_q)
      arsr_pkg::HOST_IDLE:
      begin
        if (readReq)
        begin
          state_d = arsr_pkg::HOST_WAIT_READY;
        end
      end
      arsr_pkg::HOST_WAIT_READY:
      begin
        if (!readySync_q[1])
        begin
          state_d = arsr_pkg::HOST_SETUP;
          selN_d  = 1'b0;
          cnt_d   = SETUP_LOAD;
          bits_d  = '0;
        end
      end
      arsr_pkg::HOST_SETUP, arsr_pkg::HOST_LOW:
      begin
        if (cntZero && bits_q == arsr_pkg::HOST_BITS)
        begin
          state_d = arsr_pkg::HOST_RELEASE;
          selN_d  = 1'b1;
          valid_d = 1'b1;
        end
        else if (cntZero)
        begin
          // Sample before rising; the first rise also arms the converter's shifter.
          state_d = arsr_pkg::HOST_HIGH;
          data_d  = sampled;
          bits_d  = bits_q + 5'h01;
          sclk_d  = 1'b1;
          cnt_d   = HALF_LOAD;
        end
      end
      arsr_pkg::HOST_HIGH:
      begin
        if (cntZero)
        begin
          state_d = arsr_pkg::HOST_LOW;
          sclk_d  = 1'b0;
          cnt_d   = HALF_LOAD;
        end
      end
      arsr_pkg::HOST_RELEASE:
      begin
        // Wait for the converter to withdraw ready so one result is not read twice.
        if (readySync_q[1])
        begin
          state_d = arsr_pkg::HOST_IDLE;
        end
      end
      default:
      begin
        state_d = arsr_pkg::HOST_IDLE;
        selN_d  = 1'b1;
        sclk_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      readySync_q <= 2'h3;
      dataSync_q  <= 2'h0;
      state_q     <= arsr_pkg::HOST_IDLE;
      cnt_q       <= '0;
      bits_q      <= '0;
      data_q      <= '0;
      selN_q      <= 1'b1;
      sclk_q      <= 1'b0;
      valid_q     <= 1'b0;
      busy_q      <= 1'b0;
    end
    else
    begin
      readySync_q <= {readySync_q[0], link.resultReadyN};
      dataSync_q  <= {dataSync_q[0], link.serialLine};
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      bits_q      <= bits_d;
      data_q      <= data_d;
      selN_q      <= selN_d;
      sclk_q      <= sclk_d;
      valid_q     <= valid_d;
      busy_q      <= (state_d != arsr_pkg::HOST_IDLE);
    end
  end

  assign link.selectN = selN_q;
  assign link.shiftClk = sclk_q;
  assign readData      = data_q;
  assign readValid     = valid_q;
  assign busy          = busy_q;

endmodule // arsr_host

// ==== bench/arsr_link_chk.sv ====
/*
  Concurrent checks on the readout link pins, sampled on the master clock.
  Assumes rst_n is the converter end's reset and every other input is a link signal.
*/
`timescale 1ns/1ps
module arsr_link_chk (
  // Clock and reset.
  input wire logic masterClk,
  input wire logic rst_n,
  // Link pins.
  input wire logic selectN,
  input wire logic shiftClk,
  input wire logic serialResultOut,
  input wire logic serialResultOe,
  input wire logic resultReadyN
);
  logic       shiftPrev_q;
  logic       selPrev_q;
  logic       armed_q;
  logic       armed_d;
  logic [4:0] fallCnt_q;
  logic [4:0] fallCnt_d;
  logic [2:0] selLow_q;
  logic [2:0] selLow_d;
  wire  logic shiftFell;
  wire  logic shiftRose;
  wire  logic selFell;

  assign shiftFell = shiftPrev_q & ~shiftClk & ~selectN;
  assign shiftRose = ~shiftPrev_q & shiftClk & ~selectN;
  assign selFell   = selPrev_q & ~selectN;
  assign fallCnt_d = selFell ? 5'h00 : shiftFell ? fallCnt_q + 5'h01 : fallCnt_q;
  assign armed_d   = selFell ? 1'b0 : shiftRose ? 1'b1 : armed_q;
  // Saturates so a long select never wraps back under the setup figure.
  assign selLow_d  = selectN ? 3'h0 : (selLow_q == 3'h7) ? selLow_q : selLow_q + 3'h1;

  always_ff @(posedge masterClk)
  begin
    shiftPrev_q <= rst_n & shiftClk;
    selPrev_q   <= ~rst_n | selectN;
    armed_q     <= rst_n & armed_d;
    fallCnt_q   <= rst_n ? fallCnt_d : 5'h00;
    selLow_q    <= rst_n ? selLow_d : 3'h0;
  end

  default clocking cb @(posedge masterClk); endclocking
  default disable iff (!rst_n);

  a_oe_needs_select: assert property ($rose(serialResultOe) |->
    !resultReadyN && !$past(selectN, 2))
    else $error("data driven without a selected ready port");
  a_out_on_fall: assert property (serialResultOe && $past(serialResultOe) &&
    $changed(serialResultOut) |->
    !$past(shiftClk, 1) && ($past(shiftClk, 3) || $past(shiftClk, 4)))
    else $error("data bit changed without a shift clock fall");
  a_armed_before_shift: assert property (serialResultOe && $past(serialResultOe) &&
    $changed(serialResultOut) |-> armed_q)
    else $error("data bit advanced before a rising shift edge");
  a_word_twenty_bits: assert property ($rose(resultReadyN) |-> fallCnt_q == 5'h14)
    else $error("port released after a wrong number of shifts");
  a_release_with_ready: assert property ($rose(resultReadyN) |-> $fell(serialResultOe))
    else $error("output not released after the last bit");
  a_load_when_idle: assert property ($fell(resultReadyN) |-> !serialResultOe)
    else $error("result loaded while the port was shifting");
  a_ready_holds: assert property (!resultReadyN && selectN && $past(selectN) |=>
    !resultReadyN)
    else $error("ready flag dropped without a read");
  a_shift_only_selected: assert property ($changed(shiftClk) |-> !selectN)
    else $error("shift clock moved while the port was not selected");
  a_select_setup: assert property ($rose(shiftClk) |-> selLow_q >= 3'h3)
    else $error("shift clock rose too soon after select");

  c_result_ready: cover property ($fell(resultReadyN));
  c_port_drives:  cover property ($rose(serialResultOe));
  c_word_read:    cover property ($rose(resultReadyN));
endmodule // arsr_link_chk

// ==== bench/adc_result_serial_readout_bench.sv ====
/*
  Testbench joining the converter end and the reader end over the link.
  Assumes both ends share one reset pin, held past several master clock edges.
*/
`timescale 1ns/1ps
`define CHK(nm, expv, gotv) \
  begin \
    nTests++; \
    if ((gotv) !== (expv)) \
    begin \
      miscompares++; \
      $display("unexpected %s: expected %h, seen %h", nm, expv, gotv); \
    end \
  end
module adc_result_serial_readout_bench;
  logic        core_clk;
  logic        masterClk;
  logic        rst_n;
  logic        convertCmd;
  logic        channelPick;
  logic        polaritySelect;
  logic [19:0] filterWordA;
  logic [19:0] filterWordB;
  logic        overRangeA;
  logic        overRangeB;
  logic        underRangeA;
  logic        underRangeB;
  logic        converting;
  logic        readReq;
  logic [19:0] readData;
  logic        readValid;
  logic        busy;
  logic [19:0] wireWord;
  int          miscompares;
  int          nTests;
  int          mclkCount;
  int          fallAt;

  arsr_link_if link (.masterClk(masterClk));
  arsr_device i_arsr_device (.link(link), .rst_n(rst_n), .convertCmd(convertCmd),
    .channelPick(channelPick), .polaritySelect(polaritySelect), .filterWordA(filterWordA),
    .overRangeA(overRangeA), .underRangeA(underRangeA), .filterWordB(filterWordB),
    .overRangeB(overRangeB), .underRangeB(underRangeB), .converting(converting));
  arsr_host #(.MCLK_PERIOD_NS(125)) i_arsr_host (.core_clk(core_clk), .rst_n(rst_n),
    .link(link), .readReq(readReq), .readData(readData), .readValid(readValid), .busy(busy));
  arsr_link_chk i_arsr_link_chk (.masterClk(masterClk), .rst_n(rst_n),
    .selectN(link.selectN), .shiftClk(link.shiftClk), .serialResultOut(link.serialResultOut),
    .serialResultOe(link.serialResultOe), .resultReadyN(link.resultReadyN));

  always #2 core_clk = ~core_clk;
  // A half period off the 2 ns grid keeps the master clock's rising edges off every core_clk edge.
  always #62.5 masterClk = ~masterClk;
  always @(posedge masterClk) mclkCount <= mclkCount + 1;
  // The wire itself is watched, independent of what the reader collects.
  always @(posedge link.shiftClk) wireWord <= {wireWord[18:0], link.serialLine};

  task end_of_test;
    $display("comparisons %0d, miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task waitReady(input logic lvl, input int limit, output int at);
    int i;
    for (i = 0; i < limit; i++)
    begin
      @(negedge masterClk);
      if (link.resultReadyN === lvl)
        break;
    end
    if (i == limit)
    begin
      miscompares++;
      $display("unexpected ready wait: expected %h, seen %h", lvl, link.resultReadyN);
      end_of_test;
    end
    at = mclkCount;
  endtask

  task waitValid(output logic [19:0] got);
    int i;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge core_clk);
      if (readValid === 1'b1)
        break;
    end
    if (i == 20000)
    begin
      miscompares++;
      $display("unexpected read wait: expected %h, seen %h", 1'b1, readValid);
      end_of_test;
    end
    got = readData;
  endtask

  task test_first_conversion;
    int          startAt;
    int          doneAt;
    logic [19:0] got;
    @(posedge core_clk);
    readReq        <= 1'b1;
    channelPick    <= 1'b1;
    polaritySelect <= 1'b1;
    filterWordA    <= 20'h0ABCD;
    filterWordB    <= 20'h12345;
    @(posedge core_clk);
    readReq    <= 1'b0;
    convertCmd <= 1'b1;
    startAt = mclkCount;
    repeat (50) @(negedge core_clk);
    `CHK("busy while waiting", 1'b1, busy)
    `CHK("select before result", 1'b1, link.selectN)
    `CHK("idle data wire", 1'b0, link.serialLine)
    waitReady(1'b0, 1700, doneAt);
    `CHK("standby conversion", 1'b1, (doneAt - startAt) inside {[1625:1628]})
    `CHK("converting held", 1'b1, converting)
    fallAt = doneAt;
    waitValid(got);
    `CHK("bipolar word", 20'h92345, got)
    `CHK("wire word", 20'h92345, wireWord)
    `CHK("ready after word", 1'b1, link.resultReadyN)
    repeat (200) @(negedge core_clk);
    `CHK("released wire", 1'b0, link.serialLine)
    `CHK("shift clock idle", 1'b0, link.shiftClk)
    `CHK("reader idle", 1'b0, busy)
    $display("test_first_conversion finished");
  endtask

  task test_held_convert;
    int          doneAt;
    logic [19:0] got;
    @(posedge core_clk);
    channelPick    <= 1'b0;
    polaritySelect <= 1'b0;
    overRangeB     <= 1'b1;
    readReq        <= 1'b1;
    @(posedge core_clk);
    readReq <= 1'b0;
    waitReady(1'b0, 1700, doneAt);
    `CHK("repeat conversion", 1622, doneAt - fallAt)
    waitValid(got);
    `CHK("clamped word", 20'hFFFFF, got)
    `CHK("clamped wire", 20'hFFFFF, wireWord)
    @(posedge core_clk);
    convertCmd <= 1'b0;
    $display("test_held_convert finished");
  endtask

  initial
  begin
    core_clk       = 1'b0;
    masterClk      = 1'b0;
    rst_n          = 1'b0;
    convertCmd     = 1'b0;
    channelPick    = 1'b0;
    polaritySelect = 1'b0;
    filterWordA    = 20'h00000;
    filterWordB    = 20'h00000;
    overRangeA     = 1'b0;
    overRangeB     = 1'b0;
    underRangeA    = 1'b0;
    underRangeB    = 1'b0;
    readReq        = 1'b0;
    wireWord       = 20'h00000;
    miscompares    = 0;
    nTests         = 0;
    mclkCount      = 0;
    fallAt         = 0;
    repeat (4) @(posedge core_clk);
    // The converter end resets on the slow clock, so it needs its own edges too.
    repeat (4) @(posedge masterClk);
    @(posedge core_clk);
    rst_n <= 1'b1;
    test_first_conversion;
    test_held_convert;
    end_of_test;
  end
endmodule // adc_result_serial_readout_bench
